// file: design/fopc_params.svh
// Constants for the flash on-board program control block.
// Assumes a 40 MHz ref_clk; included by bare name from the top only.
`ifndef FOPC_PARAMS_SVH
`define FOPC_PARAMS_SVH
`define FOPC_BOOT_WAIT_STATES 8'd100
`define FOPC_PAGE_BYTES       6'd32
`define FOPC_PAGE_MASK        8'h1F
`define FOPC_ERASED_BYTE      8'hFF
`define FOPC_MODE_BOOT_A      3'h5
`define FOPC_MODE_USER_A      3'h5
`define FOPC_MODE_USER_B      3'h7
`define FOPC_MODE_NOFLASH     3'h6
`define FOPC_CTL_RESET        8'h00
`define FOPC_BLK_RESET        8'h00
`endif

// file: design/fopc_pkg.sv
// Types for the flash on-board program control block.
// Assumes fopc_params.svh is reachable by bare name.
package fopc_pkg;
  typedef struct packed {
    logic soft_write_gate_bit;
    logic write_prepare_bit;
    logic wipe_prepare_bit;
    logic burn_strobe_bit;
    logic wipe_strobe_bit;
    logic burn_check_bit;
    logic wipe_check_bit;
    logic write_gate_bit;
  } fopc_ctl_t;
  typedef enum logic [6:0] {
    ST_IDLE    = 7'b0000001,
    ST_BOOTW   = 7'b0000010,
    ST_BOOTERS = 7'b0000100,
    ST_BOOTRUN = 7'b0001000,
    ST_HANDOFF = 7'b0010000,
    ST_USER    = 7'b0100000,
    ST_PROG    = 7'b1000000
  } fopc_state_t;
  typedef enum logic [4:0] {
    OP_NONE   = 5'b00001,
    OP_BURN   = 5'b00010,
    OP_WIPE   = 5'b00100,
    OP_BCHECK = 5'b01000,
    OP_WCHECK = 5'b10000
  } fopc_op_t;
endpackage

// file: design/fopc_top.sv
// Flash on-board program sequencer: boot entry/exit, page latch, modes.
// Assumes the CPU writes control bits as plain ports; flash array is outside.
`timescale 1ns/100ps
`default_nettype none
`include "fopc_params.svh"
module fopc_top #(
  parameter int ADDR_W = 20
) (
  // Clock and reset
  input  wire logic                ref_clk,
  input  wire logic                rst,
  input  wire logic                wdt_rst,
  // Pins
  input  wire logic                chip_rst_pin_n,
  input  wire logic [2:0]          mode_select_pins,
  input  wire logic                write_gate_pin,
  input  wire logic                boot_serial_in,
  output logic                     boot_serial_out,
  output logic                     boot_serial_out_oe_n,
  output logic                     addr_strobe_out_n,
  // Control register image
  input  wire logic                ctl_wr,
  input  wire fopc_pkg::fopc_ctl_t ctl_wdata,
  input  wire logic                blk_wr,
  input  wire logic [7:0]          blk_wdata,
  output fopc_pkg::fopc_ctl_t      flash_ctl_reg,
  output logic [7:0]               block_select_reg,
  // Serial handoff state
  input  wire logic [7:0]          baud_adjusted,
  input  wire logic                baud_adjusted_vld,
  output logic [7:0]               baud_divisor_reg,
  output logic                     rx_on_bit,
  output logic                     tx_on_bit,
  // Boot program sequencing
  input  wire logic                flash_blank,
  input  wire logic                erase_done,
  input  wire logic                boot_load_done,
  output logic                     boot_mode,
  output logic                     boot_erase_all,
  output logic                     low_timer_go,
  output logic                     user_start,
  // Flash data path
  input  wire logic                fl_wr,
  input  wire logic [ADDR_W-1:0]   fl_addr,
  input  wire logic [7:0]          fl_wdata,
  input  wire logic [15:0]         array_rdata,
  output logic [ADDR_W-1:0]        latch_addr,
  output logic [7:0]               page_data [32],
  output logic [5:0]               page_count,
  output logic                     page_error,
  output logic [15:0]              verify_rdata,
  output logic                     flash_read_block,
  output fopc_pkg::fopc_op_t       flash_op,
  output logic                     user_mode
);

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: three stages, change taken when 2nd and 3rd agree
  logic [4:0] s1_r, s2_r, s3_r, sy_r;
  logic [4:0] s1_nxt, s2_nxt, s3_nxt, sy_nxt;
  always_comb begin
    s1_nxt = {chip_rst_pin_n, mode_select_pins, write_gate_pin};
    s2_nxt = s1_r;
    s3_nxt = s2_r;
    sy_nxt = sy_r;
    for (int i = 0; i < 5; i++) begin
      if (s2_r[i] == s3_r[i]) begin
        sy_nxt[i] = s3_r[i];
      end
    end
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s1_r <= 5'h00;
      s2_r <= 5'h00;
      s3_r <= 5'h00;
      sy_r <= 5'h00;
    end else begin
      s1_r <= s1_nxt;
      s2_r <= s2_nxt;
      s3_r <= s3_nxt;
      sy_r <= sy_nxt;
    end
  end
  logic       pin_rst_n;
  logic [2:0] md_s;
  logic       wg_s;
  assign pin_rst_n = sy_r[4];
  assign md_s      = sy_r[3:1];
  assign wg_s      = sy_r[0];

  ////////////////////////////////////////////////////////////////////////
  // Mode latch at reset release
  logic       rst_pin_d_r, rst_pin_d_nxt;
  logic       boot_r, boot_nxt;
  logic       user_r, user_nxt;
  logic [2:0] md_r, md_nxt;
  logic       release_evt, in_reset;
  assign release_evt = pin_rst_n & ~rst_pin_d_r;
  assign in_reset    = ~pin_rst_n;
  always_comb begin
    rst_pin_d_nxt = pin_rst_n;
    boot_nxt      = boot_r;
    user_nxt      = user_r;
    md_nxt        = md_r;
    if (in_reset) begin
      // Mode follows pins live while reset held
      md_nxt   = md_s;
      boot_nxt = 1'b0;
      user_nxt = 1'b0;
    end else if (release_evt) begin
      // Boot: on-chip ROM mode with write gate high at release
      boot_nxt = wg_s && (md_s == `FOPC_MODE_BOOT_A);
      user_nxt = wg_s && (md_s == `FOPC_MODE_USER_A
                       || md_s == `FOPC_MODE_USER_B);
      md_nxt   = md_s;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rst_pin_d_r <= 1'b0;
      boot_r      <= 1'b0;
      user_r      <= 1'b0;
      md_r        <= 3'h0;
    end else begin
      rst_pin_d_r <= rst_pin_d_nxt;
      boot_r      <= boot_nxt;
      user_r      <= user_nxt;
      md_r        <= md_nxt;
    end
  end
  assign boot_mode = boot_r;
  assign addr_strobe_out_n = in_reset ? ~md_r[1] : 1'b1;

  ////////////////////////////////////////////////////////////////////////
  // Boot sequencer; watchdog restarts it without dropping boot mode
  fopc_pkg::fopc_state_t st_r, st_nxt;
  logic [7:0] wait_r, wait_nxt;
  logic       rx_r, rx_nxt, tx_r, tx_nxt, out_r, out_nxt;
  logic [7:0] baud_r, baud_nxt;
  logic       boot_go;
  assign boot_go = release_evt | (wdt_rst & boot_r);
  always_comb begin
    st_nxt   = st_r;
    wait_nxt = wait_r;
    rx_nxt   = rx_r;
    tx_nxt   = tx_r;
    out_nxt  = out_r;
    baud_nxt = baud_r;
    if (baud_adjusted_vld) begin
      baud_nxt = baud_adjusted;
    end
    if (in_reset) begin
      st_nxt = fopc_pkg::ST_IDLE;
    end else if (boot_go && (boot_nxt || boot_r)) begin
      st_nxt   = fopc_pkg::ST_BOOTW;
      wait_nxt = 8'h00;
      rx_nxt   = 1'b1;
      tx_nxt   = 1'b1;
    end else begin
      case (st_r)
        fopc_pkg::ST_IDLE: begin
          if (user_r) begin
            st_nxt = fopc_pkg::ST_USER;
          end
        end
        fopc_pkg::ST_BOOTW: begin
          wait_nxt = wait_r + 8'h01;
          if (wait_r == `FOPC_BOOT_WAIT_STATES - 8'h01) begin
            st_nxt = flash_blank ? fopc_pkg::ST_BOOTRUN
                                 : fopc_pkg::ST_BOOTERS;
          end
        end
        fopc_pkg::ST_BOOTERS: begin
          if (erase_done) begin
            st_nxt = fopc_pkg::ST_BOOTRUN;
          end
        end
        fopc_pkg::ST_BOOTRUN: begin
          if (boot_load_done) begin
            st_nxt = fopc_pkg::ST_HANDOFF;
          end
        end
        fopc_pkg::ST_HANDOFF: begin
          // Only serial enables change; divisor kept, out pin high
          rx_nxt  = 1'b0;
          tx_nxt  = 1'b0;
          out_nxt = 1'b1;
          st_nxt  = fopc_pkg::ST_PROG;
        end
        fopc_pkg::ST_USER, fopc_pkg::ST_PROG: begin
          st_nxt = st_r;
        end
        default: begin
          st_nxt = fopc_pkg::ST_IDLE;
        end
      endcase
    end
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_r   <= fopc_pkg::ST_IDLE;
      wait_r <= 8'h00;
      rx_r   <= 1'b0;
      tx_r   <= 1'b0;
      out_r  <= 1'b1;
      baud_r <= 8'hFF;
    end else begin
      st_r   <= st_nxt;
      wait_r <= wait_nxt;
      rx_r   <= rx_nxt;
      tx_r   <= tx_nxt;
      out_r  <= out_nxt;
      baud_r <= baud_nxt;
    end
  end
  assign rx_on_bit            = rx_r;
  assign tx_on_bit            = tx_r;
  assign baud_divisor_reg     = baud_r;
  assign boot_serial_out      = out_r;
  assign boot_serial_out_oe_n = 1'b0;
  assign boot_erase_all       = (st_r == fopc_pkg::ST_BOOTERS);
  assign low_timer_go         = (st_r == fopc_pkg::ST_BOOTRUN);
  assign user_start           = (st_r == fopc_pkg::ST_PROG)
                              | (st_r == fopc_pkg::ST_USER);
  assign user_mode            = user_r;

  ////////////////////////////////////////////////////////////////////////
  // Flash control and block select; write gate low or reset clears them
  fopc_pkg::fopc_ctl_t ctl_r, ctl_nxt;
  logic [7:0] blk_r, blk_nxt;
  logic       prog_ok_r, prog_ok_nxt;
  always_comb begin
    ctl_nxt     = ctl_r;
    blk_nxt     = blk_r;
    prog_ok_nxt = prog_ok_r;
    if (!wg_s || in_reset || wdt_rst) begin
      ctl_nxt     = `FOPC_CTL_RESET;
      blk_nxt     = `FOPC_BLK_RESET;
      prog_ok_nxt = 1'b0;
    end else begin
      if (ctl_wr) begin
        ctl_nxt = ctl_wdata;
        // Strobe honoured only on top of gate and prepare already set,
        // and only while both stay set alongside it
        prog_ok_nxt = ctl_wdata.burn_strobe_bit
                   && ctl_wdata.soft_write_gate_bit
                   && ctl_wdata.write_prepare_bit
                   && (prog_ok_r || (ctl_r.soft_write_gate_bit
                   && ctl_r.write_prepare_bit));
      end
      if (blk_wr) begin
        blk_nxt = blk_wdata;
      end
    end
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctl_r     <= `FOPC_CTL_RESET;
      blk_r     <= `FOPC_BLK_RESET;
      prog_ok_r <= 1'b0;
    end else begin
      ctl_r     <= ctl_nxt;
      blk_r     <= blk_nxt;
      prog_ok_r <= prog_ok_nxt;
    end
  end
  assign flash_ctl_reg    = ctl_r;
  assign block_select_reg = blk_r;

  // Operating mode decode
  logic gate_ok, md6;
  assign md6     = (md_r == `FOPC_MODE_NOFLASH);
  assign gate_ok = wg_s && ctl_r.write_gate_bit && !md6;
  always_comb begin
    flash_op = fopc_pkg::OP_NONE;
    if (gate_ok && prog_ok_r && ctl_r.burn_strobe_bit) begin
      flash_op = fopc_pkg::OP_BURN;
    end else if (gate_ok && ctl_r.soft_write_gate_bit
                 && ctl_r.wipe_prepare_bit && ctl_r.wipe_strobe_bit
                 && blk_r != 8'h00) begin
      flash_op = fopc_pkg::OP_WIPE;
    end else if (ctl_r.soft_write_gate_bit && ctl_r.burn_check_bit) begin
      flash_op = fopc_pkg::OP_BCHECK;
    end else if (ctl_r.soft_write_gate_bit && ctl_r.wipe_check_bit) begin
      flash_op = fopc_pkg::OP_WCHECK;
    end
  end
  assign flash_read_block = (flash_op == fopc_pkg::OP_BURN)
                          | (flash_op == fopc_pkg::OP_WIPE);

  ////////////////////////////////////////////////////////////////////////
  // 32-byte page latch and verify read
  logic [ADDR_W-1:0] la_r, la_nxt;
  logic [7:0]        pd_r [32];
  logic [7:0]        pd_nxt [32];
  logic [5:0]        cnt_r, cnt_nxt;
  logic              err_r, err_nxt;
  logic [15:0]       vr_r, vr_nxt;
  logic              page_wr, check_on;
  assign check_on = (flash_op == fopc_pkg::OP_BCHECK)
                  | (flash_op == fopc_pkg::OP_WCHECK);
  assign page_wr  = fl_wr && ctl_r.soft_write_gate_bit && !check_on
                  && !flash_read_block;
  always_comb begin
    la_nxt  = la_r;
    pd_nxt  = pd_r;
    cnt_nxt = cnt_r;
    err_nxt = err_r;
    vr_nxt  = vr_r;
    if (!ctl_r.soft_write_gate_bit) begin
      cnt_nxt = 6'd0;
    end else if (page_wr) begin
      if (cnt_r == 6'd0 || cnt_r == `FOPC_PAGE_BYTES) begin
        // Page must open on a 32-byte boundary
        la_nxt  = fl_addr;
        err_nxt = (fl_addr[7:0] & `FOPC_PAGE_MASK) != 8'h00;
        cnt_nxt = 6'd1;
        pd_nxt[fl_addr[4:0]] = fl_wdata;
      end else begin
        err_nxt = err_r || (fl_addr != la_r + ADDR_W'(cnt_r));
        cnt_nxt = cnt_r + 6'd1;
        pd_nxt[fl_addr[4:0]] = fl_wdata;
      end
    end else if (fl_wr && check_on && fl_wdata == `FOPC_ERASED_BYTE) begin
      la_nxt = fl_addr;
    end
    if (check_on) begin
      vr_nxt = array_rdata;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      la_r  <= '0;
      cnt_r <= 6'd0;
      err_r <= 1'b0;
      vr_r  <= 16'h0000;
      for (int i = 0; i < 32; i++) begin
        pd_r[i] <= `FOPC_ERASED_BYTE;
      end
    end else begin
      la_r  <= la_nxt;
      cnt_r <= cnt_nxt;
      err_r <= err_nxt;
      vr_r  <= vr_nxt;
      pd_r  <= pd_nxt;
    end
  end
  assign latch_addr   = la_r;
  assign page_data    = pd_r;
  assign page_count   = cnt_r;
  assign page_error   = err_r;
  assign verify_rdata = vr_r;

endmodule
`default_nettype wire

// file: dv/fopc_sva.sv
// Concurrent checks on the flash program sequencer ports.
// Assumes one clock domain, ref_clk, with synchronous active-high rst.
`timescale 1ns/100ps
`default_nettype none
module fopc_sva #(
  parameter int ADDR_W = 20
) (
  input wire logic                ref_clk,
  input wire logic                rst,
  input wire logic                wdt_rst,
  input wire logic                chip_rst_pin_n,
  input wire logic [2:0]          mode_select_pins,
  input wire logic                write_gate_pin,
  input wire logic                addr_strobe_out_n,
  input wire logic                fl_wr,
  input wire logic [ADDR_W-1:0]   fl_addr,
  input wire fopc_pkg::fopc_ctl_t flash_ctl_reg,
  input wire logic [7:0]          block_select_reg,
  input wire logic                rx_on_bit,
  input wire logic                tx_on_bit,
  input wire logic                boot_serial_out,
  input wire logic                boot_mode,
  input wire logic                user_mode,
  input wire logic                low_timer_go,
  input wire logic                user_start,
  input wire logic                flash_blank,
  input wire logic                boot_erase_all,
  input wire logic [5:0]          page_count,
  input wire logic                page_error,
  input wire logic                flash_read_block,
  input wire fopc_pkg::fopc_op_t  flash_op
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic [7:0] since_r;
  // Saturating count of cycles since the boot program (re)started
  always_ff @(posedge ref_clk)
    since_r <= (rst || $rose(boot_mode) || (wdt_rst && boot_mode)) ? 8'h00
             : since_r + {7'h00, since_r != 8'hFF};
  // Pin passes the synchroniser, then one edge to clear the registers
  sequence gate_low_s; !write_gate_pin [*6]; endsequence
  sequence burn_on_s; flash_op == fopc_pkg::OP_BURN; endsequence
  sequence pin_rst_s;
    (!chip_rst_pin_n && $stable(mode_select_pins)) [*6];
  endsequence
  boot_wait_a: assert property ($rose(low_timer_go) |-> since_r >= 8'd98)
    else $error("serial low timer started too early");
  erase_all_a: assert property ($rose(boot_erase_all) |-> !flash_blank)
    else $error("full erase started on a blank flash");
  serial_handoff_a: assert property ($rose(user_start) |->
    !rx_on_bit && !tx_on_bit && boot_serial_out)
    else $error("serial state wrong at handoff");
  wdt_keep_a: assert property (wdt_rst && boot_mode |=> boot_mode)
    else $error("watchdog reset dropped boot mode");
  strobe_rst_a: assert property (pin_rst_s |->
    addr_strobe_out_n == !mode_select_pins[1])
    else $error("strobe does not follow mode under reset");
  user_sel_a: assert property ($rose(user_mode) |-> write_gate_pin &&
    mode_select_pins inside {3'h5, 3'h7})
    else $error("user mode from wrong pin levels");
  read_blk_a: assert property (flash_op inside {fopc_pkg::OP_BURN,
    fopc_pkg::OP_WIPE} |-> flash_read_block)
    else $error("flash readable during program or erase");
  burn_need_a: assert property (burn_on_s |->
    flash_ctl_reg.soft_write_gate_bit && flash_ctl_reg.write_prepare_bit &&
    flash_ctl_reg.write_gate_bit)
    else $error("program mode without its enables");
  gate_clr_a: assert property (gate_low_s |->
    flash_ctl_reg == 8'h00 && block_select_reg == 8'h00)
    else $error("control not cleared with write gate low");
  page_align_a: assert property (fl_wr && flash_op == fopc_pkg::OP_NONE &&
    flash_ctl_reg.soft_write_gate_bit && page_count inside {6'd0, 6'd32} &&
    fl_addr[4:0] != 5'h00 |=> page_error)
    else $error("misaligned page start not flagged");
endmodule
bind fopc_top fopc_sva #(.ADDR_W(ADDR_W)) i_fopc_sva (.*);
`default_nettype wire

// file: dv/fopc_flash_model.sv
// Flash array and boot loader stand-in on the far side of fopc_top.
// Assumes the bench pulses make_dirty to leave written data in flash.
`timescale 1ns/100ps
`default_nettype none
module fopc_flash_model #(
  parameter int ADDR_W = 20
) (
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire logic              make_dirty,
  input  wire logic              boot_erase_all,
  input  wire logic              low_timer_go,
  input  wire logic [ADDR_W-1:0] latch_addr,
  output logic                   flash_blank,
  output logic                   erase_done,
  output logic                   boot_load_done,
  output logic [15:0]            array_rdata
);
  logic [3:0] ers_cnt;
  logic [3:0] load_cnt;
  // Answer tied to the latched address, so a stale latch shows up
  assign array_rdata    = {latch_addr[7:0], 8'h5A};
  assign erase_done     = ers_cnt >= 4'h4;
  assign boot_load_done = load_cnt >= 4'h8;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      flash_blank <= 1'b1;
      ers_cnt     <= 4'h0;
      load_cnt    <= 4'h0;
    end else begin
      if (make_dirty)
        flash_blank <= 1'b0;
      else if (erase_done)
        flash_blank <= 1'b1;
      ers_cnt  <= boot_erase_all ? ers_cnt + 4'h1 : 4'h0;
      load_cnt <= low_timer_go ? load_cnt + 4'h1 : 4'h0;
    end
  end
endmodule
`default_nettype wire

// file: dv/testbench.sv
// Self-checking bench for fopc_top with the flash stand-in.
// Assumes inputs change 2 ns after each rising ref_clk edge.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic ref_clk = 1'b0, rst = 1'b1, wdt_rst = 1'b0, make_dirty = 1'b0;
  logic chip_rst_pin_n = 1'b0, write_gate_pin = 1'b1, boot_serial_in = 1'b1;
  logic [2:0] mode_select_pins = 3'h5;
  logic ctl_wr = 1'b0, blk_wr = 1'b0, baud_adjusted_vld = 1'b0, fl_wr = 1'b0;
  logic [7:0] blk_wdata = 8'h00, baud_adjusted = 8'h1A, fl_wdata = 8'h00;
  logic [19:0] fl_addr = 20'h00000, latch_addr;
  fopc_pkg::fopc_ctl_t ctl_wdata = 8'h00, flash_ctl_reg;
  fopc_pkg::fopc_op_t flash_op;
  logic boot_serial_out, boot_serial_out_oe_n, addr_strobe_out_n, rx_on_bit;
  logic tx_on_bit, boot_mode, boot_erase_all, low_timer_go, user_start;
  logic page_error, flash_read_block, user_mode, flash_blank, erase_done;
  logic boot_load_done;
  logic [7:0] block_select_reg, baud_divisor_reg, page_data [32];
  logic [5:0] page_count;
  logic [15:0] verify_rdata, array_rdata;
  int bad_count = 0, tests_run = 0;
  // Strobe with prepare in one write, then strobe with prepare dropped
  logic [7:0] seq [12] = '{8'h81, 8'hD1, 8'h91, 8'hC0, 8'hD0, 8'hC1,
                           8'hD1, 8'hC1, 8'h81, 8'h85, 8'hA9, 8'h83};
  fopc_pkg::fopc_op_t ops [12] = '{fopc_pkg::OP_NONE, fopc_pkg::OP_NONE,
    fopc_pkg::OP_NONE, fopc_pkg::OP_NONE, fopc_pkg::OP_NONE,
    fopc_pkg::OP_NONE, fopc_pkg::OP_BURN, fopc_pkg::OP_NONE,
    fopc_pkg::OP_NONE, fopc_pkg::OP_BCHECK, fopc_pkg::OP_WIPE,
    fopc_pkg::OP_WCHECK};
  fopc_top i_fopc_top (.*);
  fopc_flash_model i_fopc_flash_model (.*);
  always #12.5 ref_clk = ~ref_clk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      bad_count++;
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #2;
  endtask
  task automatic ctl(input logic [7:0] v);
    ctl_wdata = v;
    ctl_wr = 1'b1;
    tick(1);
    ctl_wr = 1'b0;
    tick(1);
  endtask
  task automatic fl(input logic [19:0] a, input logic [7:0] d);
    fl_addr = a;
    fl_wdata = d;
    fl_wr = 1'b1;
    tick(1);
    fl_wr = 1'b0;
    tick(1);
  endtask
  // Reset pin held well past the 20-clock minimum; pins move only under it
  task automatic pin_reset(input logic [2:0] md, input logic wg);
    chip_rst_pin_n = 1'b0;
    tick(2);
    mode_select_pins = md;
    write_gate_pin = wg;
    tick(22);
    chk(addr_strobe_out_n, !md[1]);
    chip_rst_pin_n = 1'b1;
    tick(8);
  endtask
  task automatic wait_start;
    int n;
    for (n = 0; n < 600 && user_start !== 1'b1; n++) tick(1);
    chk(user_start, 1'b1);
  endtask
  task automatic test_done;
    if (bad_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #(25 * 20000);
    bad_count++;
    test_done();
  end
  initial begin
    tick(8);
    rst = 1'b0;
    make_dirty = 1'b1;
    tick(1);
    make_dirty = 1'b0;
    pin_reset(3'h5, 1'b1);
    chk(boot_mode, 1'b1);
    baud_adjusted_vld = 1'b1;
    tick(1);
    baud_adjusted_vld = 1'b0;
    wait_start();
    chk({rx_on_bit, tx_on_bit, boot_serial_out, boot_serial_out_oe_n},
        4'b0010);
    chk(baud_divisor_reg, 8'h1A);
    wdt_rst = 1'b1;
    tick(1);
    wdt_rst = 1'b0;
    tick(2);
    chk({boot_mode, user_start}, 2'b10);
    wait_start();
    pin_reset(3'h7, 1'b0);
    chk({boot_mode, user_mode}, 2'b00);
    pin_reset(3'h6, 1'b0);
    chk(user_mode, 1'b0);
    pin_reset(3'h7, 1'b1);
    chk({boot_mode, user_mode}, 2'b01);
    ctl(8'h81);
    for (int i = 0; i < 32; i++) fl(20'h00040 + i, i[7:0]);
    chk({page_count, page_data[5], page_error}, {6'd32, 8'h05, 1'b0});
    chk(latch_addr, 20'h00040);
    fl(20'h00043, 8'hFF);
    chk(page_error, 1'b1);
    blk_wdata = 8'h01;
    blk_wr = 1'b1;
    tick(1);
    blk_wr = 1'b0;
    for (int i = 0; i < 12; i++) begin
      ctl(seq[i]);
      chk(flash_op, ops[i]);
      if (i == 9) begin
        fl(20'h00046, 8'hFF);
        chk({latch_addr, verify_rdata}, {20'h00046, 16'h465A});
      end
    end
    write_gate_pin = 1'b0;
    tick(6);
    chk({flash_ctl_reg, block_select_reg}, 16'h0000);
    ctl(8'hC1);
    chk(flash_ctl_reg, 8'h00);
    write_gate_pin = 1'b1;
    test_done();
  end
endmodule
`default_nettype wire
